// ==== bench/bfs_breaker_model.sv ====
// Behavioural breaker seen through its two position contacts.
// Assumes the bench drives open_cmd and stuck on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module bfs_breaker_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Command and fault injection
  input wire logic open_cmd,
  input wire logic stuck,
  // Contact pins
  output logic pos_open_pin,
  output logic pos_closed_pin
);
  logic [1:0] trav_r;
  // Two-cycle travel, both contacts low midway; stuck never leaves closed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trav_r <= 2'h0;
    end else if (open_cmd && !stuck && trav_r != 2'h2) begin
      trav_r <= trav_r + 2'h1;
    end else if (!open_cmd && trav_r != 2'h0) begin
      trav_r <= trav_r - 2'h1;
    end
  end
  // Contact levels
  assign pos_open_pin = (trav_r == 2'h2);
  assign pos_closed_pin = (trav_r == 2'h0);
endmodule
`default_nettype wire

// ==== bench/bfs_core_tb.sv ====
// Self-checking bench for bfs_core with a breaker model on the contacts.
// Assumes hdl/ on the include path; timer load kept short at TL cycles.
`timescale 1ns/1ps
`default_nettype none
`include "bfs_regs.svh"
module bfs_core_tb;
  import bfs_pkg::*;
  localparam int TL = 20;
  logic sys_clk, rst, pos_open_pin, pos_closed_pin, cur_high_w1, cur_high_w2;
  logic freq_dev_high, lock_ack, bf_trip, bf_lock, open_cmd, stuck;
  logic [`BFS_NEXT-1:0] ext_trig_pin;
  bfs_cfg_type cfg;
  bfs_src_type [`BFS_NSRC-1:0] src;
  bfs_status_type status;
  int bad_count, n_compared, n;
  logic e;

  // Design and far side
  bfs_core uut (.sys_clk(sys_clk), .rst(rst), .cfg(cfg), .src(src), .ext_trig_pin(ext_trig_pin),
    .pos_open_pin(pos_open_pin), .pos_closed_pin(pos_closed_pin), .cur_high_w1(cur_high_w1),
    .cur_high_w2(cur_high_w2), .freq_dev_high(freq_dev_high), .lock_ack(lock_ack),
    .bf_trip(bf_trip), .bf_lock(bf_lock), .status(status));
  bfs_breaker_model brk (.sys_clk(sys_clk), .rst(rst), .open_cmd(open_cmd), .stuck(stuck),
    .pos_open_pin(pos_open_pin), .pos_closed_pin(pos_closed_pin));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s", $time, m);
      bad_count++;
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic flag(input int s);
    case (s)
      0: return bf_trip;
      1: return status.standby;
      2: return status.rejected;
      default: return status.timing;
    endcase
  endfunction

  // Bounded wait; a hang counts as a mismatch and closes the run
  task automatic wait_flag(input int s, input int lim);
    n = 0;
    while (flag(s) !== 1'b1) begin
      tick(1);
      n++;
      if (n > lim) begin
        $display("MISMATCH %0t timeout on flag %0d", $time, s);
        bad_count++;
        give_verdict();
      end
    end
  endtask

  task automatic fire(input int i, input logic cu, input logic ex, input logic ob);
    @(posedge sys_clk);
    src[i] <= '{trip: 1'b1, is_cur: cu, is_ext: ex, on_breaker: ob};
  endtask

  // Single-cycle trip, then released
  task automatic pulse(input int i, input logic cu, input logic ex, input logic ob);
    fire(i, cu, ex, ob);
    @(posedge sys_clk);
    src[i] <= '0;
  endtask

  // Drop triggers, open the breaker, ack, back to stand-by, reclose
  task automatic settle();
    @(posedge sys_clk);
    src <= '0;
    ext_trig_pin <= '0;
    open_cmd <= 1'b1;
    stuck <= 1'b0;
    freq_dev_high <= 1'b0;
    lock_ack <= 1'b1;
    wait_flag(1, 40);
    @(posedge sys_clk);
    open_cmd <= 1'b0;
    lock_ack <= 1'b0;
    tick(8);
  endtask

  // One supervision run with a held trigger under a given scheme
  task automatic sup(input bfs_scheme_type sch, input logic meas, input logic ws, input logic dev,
                     input logic c1, input logic c2, input logic po, input logic exp, input logic blk);
    @(posedge sys_clk);
    cfg.scheme <= sch;
    cfg.has_cur_meas <= meas;
    cfg.winding_sel <= ws;
    freq_dev_high <= dev;
    cur_high_w1 <= c1;
    cur_high_w2 <= c2;
    open_cmd <= po;
    tick(8);
    fire(0, 1'b1, 1'b0, 1'b1);
    tick(3);
    chk(status.blocked, blk, "blocked flag");
    tick(TL + 3);
    chk(bf_trip, exp, "trip outcome of scheme");
    settle();
  endtask

  initial begin
    rst = 1'b1;
    cfg = '{scheme: BFS_SCH_POS, trig_mode: BFS_TRG_ALL, winding_sel: 1'b0, has_cur_meas: 1'b1,
            wide_freq: 1'b1, tmr_load: 16'(TL)};
    src = '0;
    ext_trig_pin = '0;
    {cur_high_w1, cur_high_w2, freq_dev_high, lock_ack, open_cmd, stuck} = 6'h00;
    bad_count = 0;
    n_compared = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    tick(8);
    // Stuck breaker, one-cycle trigger: timer runs on and trips
    @(posedge sys_clk);
    stuck <= 1'b1;
    open_cmd <= 1'b1;
    pulse(0, 1'b1, 1'b0, 1'b1);
    wait_flag(0, TL + 4);
    chk(n >= TL - 1, 1'b1, "trip too early");
    chk(bf_lock, 1'b1, "lock with trip");
    tick(3);
    chk(bf_trip, 1'b0, "trip held after triggers gone");
    chk(bf_lock, 1'b1, "lock not latched");
    @(posedge sys_clk);
    lock_ack <= 1'b1;
    @(posedge sys_clk);
    lock_ack <= 1'b0;
    tick(1);
    chk(bf_lock, 1'b0, "lock ack");
    settle();
    // Retrigger while timing does not restart the timer
    @(posedge sys_clk);
    stuck <= 1'b1;
    pulse(0, 1'b1, 1'b0, 1'b1);
    tick(10);
    pulse(1, 1'b0, 1'b1, 1'b1);
    wait_flag(0, TL - 5);
    settle();
    // Opening with trigger held: rejected, then stand-by on release
    fire(0, 1'b1, 1'b0, 1'b1);
    tick(5);
    @(posedge sys_clk);
    open_cmd <= 1'b1;
    wait_flag(2, 12);
    tick(TL);
    chk(status.rejected, 1'b1, "left rejected early");
    chk(bf_trip, 1'b0, "trip after opening");
    @(posedge sys_clk);
    src <= '0;
    tick(2);
    chk(status.standby, 1'b1, "no return to stand-by");
    settle();
    // Scheme table
    sup(BFS_SCH_POS, 1, 0, 0, 1, 1, 1, 0, 0);
    sup(BFS_SCH_CUR, 1, 0, 0, 0, 1, 0, 0, 0);
    sup(BFS_SCH_CUR, 1, 0, 0, 1, 0, 1, 1, 0);
    sup(BFS_SCH_CUR, 1, 1, 0, 0, 1, 1, 1, 0);
    sup(BFS_SCH_BOTH, 1, 0, 0, 1, 1, 1, 0, 0);
    sup(BFS_SCH_BOTH, 1, 0, 0, 1, 1, 0, 1, 0);
    sup(BFS_SCH_BOTH, 1, 0, 0, 0, 0, 0, 0, 0);
    sup(BFS_SCH_BOTH, 1, 0, 1, 0, 0, 0, 1, 0);
    sup(BFS_SCH_CUR, 0, 0, 0, 0, 0, 0, 1, 0);
    sup(BFS_SCH_CUR, 1, 0, 1, 1, 1, 0, 0, 1);
    // Every trigger mode against every trip class and assignment
    @(posedge sys_clk);
    cfg.scheme <= BFS_SCH_POS;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 6; c++) begin
        e = (c % 2 == 1) && (m == 0 || (m == 1 && c < 2) || (m == 2 && c / 2 == 1));
        @(posedge sys_clk);
        cfg.trig_mode <= bfs_trig_mode_type'(m);
        fire((m + c) % `BFS_NSRC, c < 2, c / 2 == 1, c % 2 == 1);
        tick(2);
        chk(status.timing, e, "trip class start");
        settle();
      end
    end
    // Extra trigger pins start the block in mode none
    for (int i = 0; i < `BFS_NEXT; i++) begin
      @(posedge sys_clk);
      ext_trig_pin[i] <= 1'b1;
      wait_flag(3, 10);
      chk(status.timing, 1'b1, "extra trigger start");
      settle();
    end
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== hdl/bfs_core.sv ====
// Breaker failure supervision: start decode, supervision timer, states,
// backup trip and latched lock.
// Assumes trip sources, current comparisons and frequency flag come from
// logic on sys_clk; position contacts and extra triggers are raw pins.
// What this block does
// RULE1 - Once started, timer runs on even if the trigger drops
// RULE2 - Timer expiring unstopped raises the backup breaker failure trip
// RULE3 - Detected breaker opening stops the timer, per selected scheme
// RULE4 - Opening seen while triggers remain active enters the rejected state
// RULE5 - Rejected returns to stand-by once all triggers have dropped
// RULE6 - Lock rises with the trip, stays latched until operator acknowledge
// RULE7 - Current scheme fails when current stays at or above threshold
// RULE8 - Position scheme fails when contacts never showed open
// RULE9 - Combined scheme fails only with current high and position not open
// RULE10 - Wide-frequency variant blocks current scheme on frequency deviation
// RULE11 - During deviation the combined scheme acts as position scheme
// RULE12 - Mode all: every trip on this breaker starts the block
// RULE13 - Mode current: only current trips on this breaker start it
// RULE14 - Mode external: only external trips on this breaker start it
// RULE15 - Mode none: only the extra trigger inputs start the block
// RULE16 - Trip classes need breaker assignment; extra triggers do not
// RULE17 - Supervised current taken from the selected winding side
// RULE18 - Without current measurement only the position scheme exists
// RULE19 - Timer starts only from stand-by, never restarts meanwhile
`timescale 1ns/1ps
`default_nettype none
`include "bfs_regs.svh"

module bfs_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Settings
  input wire bfs_pkg::bfs_cfg_type cfg,
  // Trip manager sources
  input wire bfs_pkg::bfs_src_type [`BFS_NSRC-1:0] src,
  // Extra assignable trigger pins
  input wire logic [`BFS_NEXT-1:0] ext_trig_pin,
  // Breaker position contact pins
  input wire logic pos_open_pin,
  input wire logic pos_closed_pin,
  // Current comparison per winding, at or above threshold
  input wire logic cur_high_w1,
  input wire logic cur_high_w2,
  // Frequency deviation beyond limit
  input wire logic freq_dev_high,
  // Operator acknowledge of the lock
  input wire logic lock_ack,
  // Results
  output var logic bf_trip,
  output var logic bf_lock,
  output var bfs_pkg::bfs_status_type status
);
  import bfs_pkg::*;

  logic [`BFS_NEXT-1:0] ext_trig;
  logic pos_open;
  logic pos_closed;
  logic [`BFS_NSRC-1:0] src_start;
  logic trig_any;
  logic cur_high;
  logic cur_block;
  bfs_scheme_type eff_scheme;
  logic brk_open;
  logic expire;
  bfs_state_type state_r;
  bfs_state_type state_nxt;
  logic [`BFS_TMR_W-1:0] tmr_r;
  logic trip_r;
  logic lock_r;
  bfs_status_type status_r;

  // Pins cross into sys_clk through the agreement synchroniser
  bfs_sync #(
    .W(`BFS_NEXT + 2)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({ext_trig_pin, pos_open_pin, pos_closed_pin}),
    .level_out({ext_trig, pos_open, pos_closed})
  );

  // Per-source start decode by trigger mode and breaker assignment
  for (genvar i = 0; i < `BFS_NSRC; i++) begin : g_src
    logic cls_hit;
    always_comb begin
      case (cfg.trig_mode)
        BFS_TRG_ALL: cls_hit = src[i].trip; // [RULE12]
        BFS_TRG_CUR: cls_hit = src[i].trip & src[i].is_cur; // [RULE13]
        BFS_TRG_EXT: cls_hit = src[i].trip & src[i].is_ext; // [RULE14]
        default: cls_hit = 1'b0; // [RULE15]
      endcase
    end
    // Only trips routed to this breaker count
    assign src_start[i] = cls_hit & src[i].on_breaker; // [RULE16]
  end

  // Extra triggers bypass the breaker assignment
  assign trig_any = (|src_start) | (|ext_trig); // [RULE16]

  // Current from the chosen winding side
  assign cur_high = cfg.winding_sel ? cur_high_w2 : cur_high_w1; // [RULE17]

  // Current scheme unusable on frequency excursion
  assign cur_block = cfg.wide_freq & freq_dev_high; // [RULE10]

  // Effective scheme after variant and frequency limits
  always_comb begin
    eff_scheme = cfg.scheme;
    if (!cfg.has_cur_meas) begin
      eff_scheme = BFS_SCH_POS; // [RULE18]
    end else if (cur_block && cfg.scheme == BFS_SCH_BOTH) begin
      eff_scheme = BFS_SCH_POS; // [RULE11]
    end
  end

  // Breaker-open detection; failure is the absence of it at expiry
  always_comb begin
    case (eff_scheme)
      BFS_SCH_POS: brk_open = pos_open & ~pos_closed; // [RULE8]
      BFS_SCH_CUR: brk_open = ~cur_high; // [RULE7]
      BFS_SCH_BOTH: brk_open = ~cur_high | (pos_open & ~pos_closed); // [RULE9]
      default: brk_open = 1'b1;
    endcase
  end

  // Last count of a run that was not stopped
  assign expire = (tmr_r >= cfg.tmr_load) || (tmr_r >= `BFS_TMR_MIN && cfg.tmr_load < `BFS_TMR_MIN);

  // State sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BFS_ST_STANDBY: begin
        if (trig_any && !(cur_block && eff_scheme == BFS_SCH_CUR)) begin
          state_nxt = BFS_ST_TIMING; // [RULE19]
        end
      end
      BFS_ST_TIMING: begin
        if (cur_block && eff_scheme == BFS_SCH_CUR) begin
          state_nxt = BFS_ST_STANDBY; // [RULE10]
        end else if (brk_open) begin
          // Opening stops the timer; linger while triggers hold
          state_nxt = trig_any ? BFS_ST_REJECTED : BFS_ST_STANDBY; // [RULE3] [RULE4]
        end else if (expire) begin
          state_nxt = BFS_ST_FAILED; // [RULE2]
        end
      end
      BFS_ST_REJECTED: begin
        if (!trig_any) begin
          state_nxt = BFS_ST_STANDBY; // [RULE5]
        end
      end
      BFS_ST_FAILED: begin
        // Trip drops with the triggers; the lock stays behind
        if (!trig_any) begin
          state_nxt = BFS_ST_STANDBY;
        end
      end
      default: state_nxt = BFS_ST_STANDBY;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= BFS_ST_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Supervision timer counts in TIMING regardless of the trigger level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tmr_r <= `BFS_TMR_RST;
    end else if (state_r == BFS_ST_TIMING && state_nxt == BFS_ST_TIMING) begin
      tmr_r <= tmr_r + 1'b1; // [RULE1]
    end else begin
      tmr_r <= `BFS_TMR_RST;
    end
  end

  // Backup trip follows the failed state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trip_r <= `BFS_TRIP_RST;
    end else begin
      trip_r <= (state_nxt == BFS_ST_FAILED); // [RULE2]
    end
  end

  // Lock sets with the trip; a new failure beats a same-cycle acknowledge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_r <= `BFS_LOCK_RST;
    end else if (state_nxt == BFS_ST_FAILED) begin
      lock_r <= 1'b1; // [RULE6]
    end else if (lock_ack) begin
      lock_r <= 1'b0; // [RULE6]
    end
  end

  // Status flags, registered so every output is a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_r <= '0;
    end else begin
      status_r.standby <= (state_nxt == BFS_ST_STANDBY);
      status_r.timing <= (state_nxt == BFS_ST_TIMING);
      status_r.rejected <= (state_nxt == BFS_ST_REJECTED);
      status_r.blocked <= cur_block && eff_scheme == BFS_SCH_CUR;
    end
  end

  assign bf_trip = trip_r;
  assign bf_lock = lock_r;
  assign status = status_r;

  // Opening detected while triggers stay: rejected next
  sequence s_open_held;
    state_r == BFS_ST_TIMING && brk_open && trig_any && !(cur_block && eff_scheme == BFS_SCH_CUR);
  endsequence

  property p_reject;
    @(posedge sys_clk) disable iff (rst)
      s_open_held |=> state_r == BFS_ST_REJECTED ##0 status.rejected;
  endproperty
  a_reject: assert property (p_reject) else $error("open with trigger did not reject"); // [RULE4]

  property p_rej_exit;
    @(posedge sys_clk) disable iff (rst)
      state_r == BFS_ST_REJECTED && !trig_any |=> state_r == BFS_ST_STANDBY;
  endproperty
  a_rej_exit: assert property (p_rej_exit) else $error("rejected did not return to stand-by"); // [RULE5]

  property p_run_on;
    @(posedge sys_clk) disable iff (rst)
      state_r == BFS_ST_TIMING && !trig_any && !brk_open && !expire && !cur_block
      |=> state_r == BFS_ST_TIMING && tmr_r == $past(tmr_r) + 1'b1;
  endproperty
  a_run_on: assert property (p_run_on) else $error("timer stopped on trigger drop"); // [RULE1]

  property p_expire_trip;
    @(posedge sys_clk) disable iff (rst)
      state_r == BFS_ST_TIMING && expire && !brk_open && !cur_block |=> bf_trip && bf_lock;
  endproperty
  a_expire_trip: assert property (p_expire_trip) else $error("expiry gave no trip"); // [RULE2]

  property p_lock_with_trip;
    @(posedge sys_clk) disable iff (rst)
      $rose(bf_trip) |-> bf_lock;
  endproperty
  a_lock_with_trip: assert property (p_lock_with_trip) else $error("lock not with trip"); // [RULE6]

  property p_lock_held;
    @(posedge sys_clk) disable iff (rst)
      bf_lock && !lock_ack |=> bf_lock;
  endproperty
  a_lock_held: assert property (p_lock_held) else $error("lock dropped without acknowledge"); // [RULE6]

  property p_no_restart;
    @(posedge sys_clk) disable iff (rst)
      state_r != BFS_ST_STANDBY ##1 state_r == BFS_ST_TIMING |-> tmr_r != `BFS_TMR_RST;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("timer restarted outside stand-by"); // [RULE19]

  property p_none_mode;
    @(posedge sys_clk) disable iff (rst)
      cfg.trig_mode == BFS_TRG_NONE && state_r == BFS_ST_STANDBY && ext_trig == '0 |=> state_r != BFS_ST_TIMING;
  endproperty
  a_none_mode: assert property (p_none_mode) else $error("trip class started block in none mode"); // [RULE15]

  property p_cur_block;
    @(posedge sys_clk) disable iff (rst)
      cfg.wide_freq && freq_dev_high && cfg.has_cur_meas && cfg.scheme == BFS_SCH_CUR
      && state_r == BFS_ST_STANDBY |=> !bf_trip && state_r != BFS_ST_TIMING;
  endproperty
  a_cur_block: assert property (p_cur_block) else $error("blocked current scheme started"); // [RULE10]

  property p_no_meas;
    @(posedge sys_clk) disable iff (rst)
      !cfg.has_cur_meas |-> eff_scheme == BFS_SCH_POS;
  endproperty
  a_no_meas: assert property (p_no_meas) else $error("current scheme without measurement"); // [RULE18]

  // Timer running and not aborted by a frequency block
  sequence s_live;
    state_r == BFS_ST_TIMING && !(cur_block && eff_scheme == BFS_SCH_CUR);
  endsequence

  // Starts only from stand-by, always from a cleared count
  property p_start;
    @(posedge sys_clk) disable iff (rst)
      state_r == BFS_ST_STANDBY && trig_any && !(cur_block && eff_scheme == BFS_SCH_CUR)
      |=> status.timing && tmr_r == `BFS_TMR_RST;
  endproperty
  a_start: assert property (p_start) else $error("start from stand-by failed"); // [RULE19]

  property p_rej_hold;
    @(posedge sys_clk) disable iff (rst)
      state_r == BFS_ST_REJECTED && trig_any |=> status.rejected && tmr_r == `BFS_TMR_RST;
  endproperty
  a_rej_hold: assert property (p_rej_hold) else $error("trigger restarted timer from rejected"); // [RULE19]

  property p_ext_start;
    @(posedge sys_clk) disable iff (rst)
      state_r == BFS_ST_STANDBY && ext_trig != '0 && !(cur_block && eff_scheme == BFS_SCH_CUR) |=> status.timing;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("extra trigger did not start"); // [RULE16]

  // Per-scheme stop and failure decisions on a live timer
  property p_pos_stop;
    @(posedge sys_clk) disable iff (rst)
      s_live ##0 (eff_scheme == BFS_SCH_POS && pos_open && !pos_closed) |=> !status.timing && !bf_trip;
  endproperty
  a_pos_stop: assert property (p_pos_stop) else $error("position open did not stop timer"); // [RULE8]

  property p_cur_stop;
    @(posedge sys_clk) disable iff (rst)
      s_live ##0 (eff_scheme == BFS_SCH_CUR && !cur_high) |=> !status.timing && !bf_trip;
  endproperty
  a_cur_stop: assert property (p_cur_stop) else $error("low current did not stop timer"); // [RULE7]

  property p_cur_fail;
    @(posedge sys_clk) disable iff (rst)
      s_live ##0 (eff_scheme == BFS_SCH_CUR && cur_high && expire) |=> bf_trip && bf_lock;
  endproperty
  a_cur_fail: assert property (p_cur_fail) else $error("high current at expiry gave no trip"); // [RULE7]

  property p_winding;
    @(posedge sys_clk) disable iff (rst)
      s_live ##0 (eff_scheme == BFS_SCH_CUR && cfg.winding_sel && cur_high_w2) |=> status.timing || bf_trip;
  endproperty
  a_winding: assert property (p_winding) else $error("second winding current ignored"); // [RULE17]

  property p_both_stop;
    @(posedge sys_clk) disable iff (rst)
      s_live ##0 (eff_scheme == BFS_SCH_BOTH && (!cur_high || (pos_open && !pos_closed))) |=> !status.timing && !bf_trip;
  endproperty
  a_both_stop: assert property (p_both_stop) else $error("combined scheme failed to stop"); // [RULE9]

  property p_dev_both;
    @(posedge sys_clk) disable iff (rst)
      s_live ##0 (cfg.scheme == BFS_SCH_BOTH && cfg.has_cur_meas && cur_block && !cur_high && !(pos_open && !pos_closed))
      |=> status.timing || bf_trip;
  endproperty
  a_dev_both: assert property (p_dev_both) else $error("combined scheme used current during deviation"); // [RULE11]

  property p_fail_hold;
    @(posedge sys_clk) disable iff (rst)
      state_r == BFS_ST_FAILED && trig_any |=> bf_trip && bf_lock;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("trip dropped while triggers held"); // [RULE2]

endmodule

`default_nettype wire

// ==== hdl/bfs_pkg.sv ====
// Types shared by the breaker failure supervision block.
// Assumes bfs_regs.svh sits beside it in hdl/.
`include "bfs_regs.svh"

package bfs_pkg;

  // Breaker-open detection scheme
  typedef enum logic [1:0] {
    BFS_SCH_POS,
    BFS_SCH_CUR,
    BFS_SCH_BOTH
  } bfs_scheme_type;

  // Which trip class starts the block
  typedef enum logic [1:0] {
    BFS_TRG_ALL,
    BFS_TRG_CUR,
    BFS_TRG_EXT,
    BFS_TRG_NONE
  } bfs_trig_mode_type;

  // Supervision state
  typedef enum logic [1:0] {
    BFS_ST_STANDBY,
    BFS_ST_TIMING,
    BFS_ST_REJECTED,
    BFS_ST_FAILED
  } bfs_state_type;

  // Static settings
  typedef struct packed {
    bfs_scheme_type scheme;
    bfs_trig_mode_type trig_mode;
    logic winding_sel;
    logic has_cur_meas;
    logic wide_freq;
    logic [`BFS_TMR_W-1:0] tmr_load;
  } bfs_cfg_type;

  // One trip source from the trip manager
  typedef struct packed {
    logic trip;
    logic is_cur;
    logic is_ext;
    logic on_breaker;
  } bfs_src_type;

  // Status flags
  typedef struct packed {
    logic standby;
    logic timing;
    logic rejected;
    logic blocked;
  } bfs_status_type;

endpackage

// ==== hdl/bfs_regs.svh ====
// Constants for the breaker failure supervision block.
// Assumes inclusion by bare name from hdl/ sources and from the bench, with hdl/ on the include path.
`ifndef BFS_REGS_SVH
`define BFS_REGS_SVH

// Supervision timer width and reset value
`define BFS_TMR_W 16
`define BFS_TMR_RST 16'h0000
// Timer floor in the expiry test; a load of 0 still expires at count 0 through the plain load compare
`define BFS_TMR_MIN 16'h0001
// Number of trip sources seen from the trip manager
`define BFS_NSRC 8
// Number of extra assignable trigger inputs
`define BFS_NEXT 3
// Output reset values
`define BFS_TRIP_RST 1'b0
`define BFS_LOCK_RST 1'b0

`endif

// ==== hdl/bfs_sync.sv ====
// Three-stage pin synchroniser with agreement check.
// Assumes asynchronous pins; output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module bfs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins and clean levels
  input wire logic [W-1:0] pin_in,
  output var logic [W-1:0] level_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Chain; first stage feeds only the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Per bit: a new value counts only when two stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic lvl_r;
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        lvl_r <= 1'b0;
      end else if (s2_r[i] == s3_r[i]) begin
        lvl_r <= s3_r[i];
      end
    end
    // One flop per bit keeps a single writer for each output bit
    assign level_out[i] = lvl_r;
  end

endmodule

`default_nettype wire
